// [hw/fspc_regs.svh]
// Offsets, fields and timing of the flash self-programming controller
// Contract
// - Erase and program act on rows of 32 words (96 bytes).
// - Flash address is table page bits 7:0 joined to the 16-bit address.
// - Low-word table access reaches word bits 15:0, word or byte mode.
// - High-byte table access reaches word bits 23:16, word or byte mode.
// - Panels hold 128 rows; pointer changes at each panel boundary.
// - 32 latches per panel, loaded in order from a 32-word aligned start.
// - Each table write is a 2-cycle single latch word write.
// - Latches reach the array only by a started cycle, one per row.
// - Low address register captures address 15:0 of last table operation.
// - High address register captures address 23:16 of last table operation.
// - Key register is write-only; 0x55 then 0xAA precede erase or program.
// - Software may write both address registers to choose the target.
// - Operation lasts nominally 2 ms; processor stalls until it ends.
// - Go bit 15 starts the operation; hardware clears it on completion.
// - Control selects erase scope, memory type and holds the start bit.
`ifndef FSPC_REGS_SVH
`define FSPC_REGS_SVH

`define FSPC_CTRL_OFS     8'h00
`define FSPC_ADRL_OFS     8'h04
`define FSPC_ADRH_OFS     8'h08
`define FSPC_KEY_OFS      8'h0C
`define FSPC_PAGE_OFS     8'h10

`define FSPC_GO_BIT       15
`define FSPC_PERMIT_BIT   14
`define FSPC_ERR_BIT      13
`define FSPC_OP_MSB       6
`define FSPC_OP_ERASE     7'h41
`define FSPC_OP_PROG      7'h01
`define FSPC_KEY_FIRST    8'h55
`define FSPC_KEY_SECOND   8'hAA

`define FSPC_ROW_WORDS    32
`define FSPC_PANEL_ROWS   128
`define FSPC_ROW_LSB      6
`define FSPC_IDX_W        5
`define FSPC_LAST_IDX     5'h1F

`define FSPC_OP_TIME_NS   2000000
`define FSPC_CLK_NS       20
`define FSPC_OP_CYCLES    (`FSPC_OP_TIME_NS / `FSPC_CLK_NS)
`define FSPC_TIMER_W      20

`define FSPC_RESP_OKAY    2'h0
`define FSPC_RESP_SLVERR  2'h2

`endif

// [hw/fspc_pkg.sv]
// Types shared by the flash self-programming controller files
`include "fspc_regs.svh"
package fspc_pkg;

    typedef enum logic [1:0] {
        FSPC_ST_IDLE  = 2'h0,
        FSPC_ST_ERASE = 2'h1,
        FSPC_ST_PROG  = 2'h2,
        FSPC_ST_WAIT  = 2'h3
    } fspc_fsm_t;

    typedef enum logic [1:0] {
        FSPC_KEY_NONE  = 2'h0,
        FSPC_KEY_HALF  = 2'h1,
        FSPC_KEY_ARMED = 2'h2
    } fspc_key_t;

    typedef logic [`FSPC_TIMER_W-1:0] fspc_timer_t;

    typedef struct packed {
        logic                  aw_got;
        logic [7:0]            aw_addr;
        logic                  w_got;
        logic [15:0]           wdata;
        logic [1:0]            wstrb;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [15:0]           rdata;
        logic [1:0]            rresp;
        logic                  go;
        logic                  permit;
        logic                  err;
        logic [6:0]            op;
        logic [15:0]           adr_lo;
        logic [7:0]            adr_hi;
        logic [7:0]            page;
        fspc_key_t             key;
        fspc_fsm_t             st;
        fspc_timer_t           timer;
        logic [`FSPC_IDX_W-1:0] idx;
        logic [1:0]            tpipe;
        logic                  t_write;
        logic                  t_high;
        logic                  t_byte;
        logic                  t_odd;
        logic [23:0]           rd_addr;
        logic [15:0]           tdata;
        logic                  erase_p;
        logic                  prog_we;
        logic [`FSPC_IDX_W-1:0] prog_idx;
    } fspc_core_t;

    typedef struct packed {
        logic [`FSPC_ROW_WORDS-1:0][23:0] mem;
        logic [23:0]                      rd;
    } fspc_mem_t;

endpackage

// [hw/fspc_latch_mem.sv]
// Row write latches: 32 words of 24 bits with byte-lane writes
`timescale 1ns/1ps
`default_nettype none
`include "fspc_regs.svh"
module fspc_latch_mem (
    input  wire logic                   clk_in,
    input  wire logic                   reset_n_in,
    input  wire logic [2:0]             wr_en_in,
    input  wire logic [`FSPC_IDX_W-1:0] wr_idx_in,
    input  wire logic [23:0]            wr_data_in,
    input  wire logic [`FSPC_IDX_W-1:0] rd_idx_in,
    output logic      [23:0]            rd_data_out
);
    fspc_pkg::fspc_mem_t q;
    fspc_pkg::fspc_mem_t n;

    // ====================================
    // Lane writes and registered read
    always_comb begin
        n = q;
        for (int l = 0; l < 3; l++) begin
            if (wr_en_in[l]) begin
                n.mem[wr_idx_in][l*8 +: 8] = wr_data_in[l*8 +: 8];
            end
        end
        n.rd = q.mem[rd_idx_in];
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign rd_data_out = q.rd;
endmodule
`default_nettype wire

// [hw/fspc_ctrl.sv]
// Flash self-programming controller with AXI4-Lite register port
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fspc_regs.svh"
module fspc_ctrl #(
    parameter int OP_CYCLES = `FSPC_OP_CYCLES
) (
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    output logic      [1:0]  s_axi_bresp_out,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    input  wire logic [7:0]  s_axi_araddr_in,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    output logic      [31:0] s_axi_rdata_out,
    output logic      [1:0]  s_axi_rresp_out,
    input  wire logic        tbl_valid_in,
    output logic             tbl_ready_out,
    input  wire logic        tbl_write_in,
    input  wire logic        tbl_high_in,
    input  wire logic        tbl_byte_in,
    input  wire logic [15:0] tbl_ea_in,
    input  wire logic [15:0] tbl_wdata_in,
    output logic             tbl_done_out,
    output logic      [15:0] tbl_rdata_out,
    output logic             core_stall_out,
    output logic      [23:0] flash_rd_addr_out,
    input  wire logic [23:0] flash_rd_data_in,
    output logic             flash_erase_out,
    output logic      [23:0] flash_row_addr_out,
    output logic             flash_prog_out,
    output logic      [4:0]  flash_prog_idx_out,
    output logic      [23:0] flash_prog_data_out
);
    localparam fspc_pkg::fspc_timer_t TIMER_LOAD =
        fspc_pkg::fspc_timer_t'(OP_CYCLES - 1);

    fspc_pkg::fspc_core_t q;
    fspc_pkg::fspc_core_t n;

    logic        aw_rdy;
    logic        w_rdy;
    logic        ar_rdy;
    logic        tbl_take;
    logic        wr_fire;
    logic        idle;
    logic [15:0] cv;
    logic [2:0]  lat_we;
    logic [23:0] lat_wd;
    logic [23:0] lat_rd;

    // ====================================
    // Helper functions
    function automatic logic [15:0] fspc_merge(
        input logic [15:0] old_v,
        input logic [15:0] new_v,
        input logic [1:0]  strb
    );
        fspc_merge = old_v;
        if (strb[0]) begin
            fspc_merge[7:0] = new_v[7:0];
        end
        if (strb[1]) begin
            fspc_merge[15:8] = new_v[15:8];
        end
    endfunction

    function automatic logic fspc_known(input logic [7:0] a);
        fspc_known = (a == `FSPC_CTRL_OFS) || (a == `FSPC_ADRL_OFS) ||
                     (a == `FSPC_ADRH_OFS) || (a == `FSPC_KEY_OFS) ||
                     (a == `FSPC_PAGE_OFS);
    endfunction

    function automatic logic [15:0] fspc_pick(
        input logic [23:0] d,
        input logic        hi,
        input logic        byte_m,
        input logic        odd
    );
        if (hi) begin
            fspc_pick = (byte_m && odd) ? 16'h0000 : {8'h00, d[23:16]};
        end else if (byte_m) begin
            fspc_pick = {8'h00, odd ? d[15:8] : d[7:0]};
        end else begin
            fspc_pick = d[15:0];
        end
    endfunction

    function automatic logic [15:0] fspc_ctrl_word(
        input fspc_pkg::fspc_core_t s
    );
        fspc_ctrl_word = 16'h0000;
        fspc_ctrl_word[`FSPC_GO_BIT] = s.go;
        fspc_ctrl_word[`FSPC_PERMIT_BIT] = s.permit;
        fspc_ctrl_word[`FSPC_ERR_BIT] = s.err;
        fspc_ctrl_word[`FSPC_OP_MSB:0] = s.op;
    endfunction

    // ====================================
    // Handshakes
    assign idle     = (q.st == fspc_pkg::FSPC_ST_IDLE);
    assign aw_rdy   = !q.aw_got && !q.bvalid;
    assign w_rdy    = !q.w_got && !q.bvalid;
    assign ar_rdy   = !q.rvalid;
    assign wr_fire  = q.aw_got && q.w_got && !q.bvalid;
    assign tbl_ready_out = idle && (q.tpipe == 2'h0);
    assign tbl_take = tbl_valid_in && tbl_ready_out;
    assign cv = fspc_merge(fspc_ctrl_word(q), q.wdata, q.wstrb);

    // ====================================
    // Latch write lanes
    assign lat_we[0] = tbl_take && tbl_write_in && !tbl_high_in &&
                       !(tbl_byte_in && tbl_ea_in[0]);
    assign lat_we[1] = tbl_take && tbl_write_in && !tbl_high_in &&
                       !(tbl_byte_in && !tbl_ea_in[0]);
    assign lat_we[2] = tbl_take && tbl_write_in && tbl_high_in &&
                       !(tbl_byte_in && tbl_ea_in[0]);
    assign lat_wd = {tbl_wdata_in[7:0],
                     tbl_byte_in ? tbl_wdata_in[7:0] : tbl_wdata_in[15:8],
                     tbl_wdata_in[7:0]};

    fspc_latch_mem u_latch (
        .clk_in      (clk_in),
        .reset_n_in  (reset_n_in),
        .wr_en_in    (lat_we),
        .wr_idx_in   (tbl_ea_in[`FSPC_IDX_W:1]),
        .wr_data_in  (lat_wd),
        .rd_idx_in   (q.idx),
        .rd_data_out (lat_rd)
    );

    // ====================================
    // Next state
    always_comb begin
        n = q;
        n.erase_p = 1'b0;
        n.prog_we = 1'b0;

        // Write capture
        if (s_axi_awvalid_in && aw_rdy) begin
            n.aw_got  = 1'b1;
            n.aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && w_rdy) begin
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata_in[15:0];
            n.wstrb = s_axi_wstrb_in[1:0];
        end
        if (q.bvalid && s_axi_bready_in) begin
            n.bvalid = 1'b0;
        end

        // Table operations
        n.tpipe = {q.tpipe[0], tbl_take};
        if (tbl_take) begin
            n.t_write = tbl_write_in;
            n.t_high  = tbl_high_in;
            n.t_byte  = tbl_byte_in;
            n.t_odd   = tbl_ea_in[0];
            n.adr_lo  = tbl_ea_in;
            n.adr_hi  = q.page;
            n.rd_addr = {q.page, tbl_ea_in};
        end
        if (q.tpipe[0] && !q.t_write) begin
            n.tdata = fspc_pick(flash_rd_data_in, q.t_high, q.t_byte,
                                q.t_odd);
        end

        // Register writes
        if (wr_fire) begin
            n.aw_got = 1'b0;
            n.w_got  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = fspc_known(q.aw_addr) ? `FSPC_RESP_OKAY
                                             : `FSPC_RESP_SLVERR;
            if (idle) begin
                unique case (q.aw_addr)
                    `FSPC_CTRL_OFS: begin
                        n.permit = cv[`FSPC_PERMIT_BIT];
                        n.op     = cv[`FSPC_OP_MSB:0];
                        n.err    = cv[`FSPC_ERR_BIT];
                        n.key    = fspc_pkg::FSPC_KEY_NONE;
                        if (cv[`FSPC_GO_BIT]) begin
                            if (q.key == fspc_pkg::FSPC_KEY_ARMED &&
                                cv[`FSPC_PERMIT_BIT] &&
                                (cv[`FSPC_OP_MSB:0] == `FSPC_OP_ERASE ||
                                 cv[`FSPC_OP_MSB:0] == `FSPC_OP_PROG)) begin
                                n.go    = 1'b1;
                                n.timer = TIMER_LOAD;
                                n.idx   = '0;
                                n.st    = (cv[`FSPC_OP_MSB:0] ==
                                           `FSPC_OP_ERASE)
                                          ? fspc_pkg::FSPC_ST_ERASE
                                          : fspc_pkg::FSPC_ST_PROG;
                            end else begin
                                n.err = 1'b1;
                            end
                        end
                    end
                    `FSPC_ADRL_OFS: begin
                        n.adr_lo = fspc_merge(q.adr_lo, q.wdata,
                                              q.wstrb);
                    end
                    `FSPC_ADRH_OFS: begin
                        if (q.wstrb[0]) begin
                            n.adr_hi = q.wdata[7:0];
                        end
                    end
                    `FSPC_KEY_OFS: begin
                        if (q.wstrb[0]) begin
                            if (q.wdata[7:0] == `FSPC_KEY_FIRST) begin
                                n.key = fspc_pkg::FSPC_KEY_HALF;
                            end else if (q.wdata[7:0] == `FSPC_KEY_SECOND &&
                                q.key == fspc_pkg::FSPC_KEY_HALF) begin
                                n.key = fspc_pkg::FSPC_KEY_ARMED;
                            end else begin
                                n.key = fspc_pkg::FSPC_KEY_NONE;
                            end
                        end
                    end
                    `FSPC_PAGE_OFS: begin
                        if (q.wstrb[0]) begin
                            n.page = q.wdata[7:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Register reads
        if (q.rvalid && s_axi_rready_in) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid_in && ar_rdy) begin
            n.rvalid = 1'b1;
            n.rresp  = fspc_known(s_axi_araddr_in) ? `FSPC_RESP_OKAY
                                                   : `FSPC_RESP_SLVERR;
            unique case (s_axi_araddr_in)
                `FSPC_CTRL_OFS: n.rdata = fspc_ctrl_word(q);
                `FSPC_ADRL_OFS: n.rdata = q.adr_lo;
                `FSPC_ADRH_OFS: n.rdata = {8'h00, q.adr_hi};
                `FSPC_PAGE_OFS: n.rdata = {8'h00, q.page};
                default:        n.rdata = 16'h0000;
            endcase
        end

        // Operation sequencer
        if (!idle && q.timer != '0) begin
            n.timer = q.timer - 1'b1;
        end
        unique case (q.st)
            fspc_pkg::FSPC_ST_IDLE: begin
            end
            fspc_pkg::FSPC_ST_ERASE: begin
                n.erase_p = 1'b1;
                n.st      = fspc_pkg::FSPC_ST_WAIT;
            end
            fspc_pkg::FSPC_ST_PROG: begin
                n.prog_we  = 1'b1;
                n.prog_idx = q.idx;
                n.idx      = q.idx + 1'b1;
                if (q.idx == `FSPC_LAST_IDX) begin
                    n.st = fspc_pkg::FSPC_ST_WAIT;
                end
            end
            fspc_pkg::FSPC_ST_WAIT: begin
                if (q.timer == '0) begin
                    n.st = fspc_pkg::FSPC_ST_IDLE;
                    n.go = 1'b0;
                end
            end
        endcase
    end

    // ====================================
    // State register
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // ====================================
    // Outputs
    assign s_axi_awready_out   = aw_rdy;
    assign s_axi_wready_out    = w_rdy;
    assign s_axi_bvalid_out    = q.bvalid;
    assign s_axi_bresp_out     = q.bresp;
    assign s_axi_arready_out   = ar_rdy;
    assign s_axi_rvalid_out    = q.rvalid;
    assign s_axi_rdata_out     = {16'h0000, q.rdata};
    assign s_axi_rresp_out     = q.rresp;
    assign tbl_done_out        = q.tpipe[1];
    assign tbl_rdata_out       = q.tdata;
    assign core_stall_out      = !idle;
    assign flash_rd_addr_out   = q.rd_addr;
    assign flash_erase_out     = q.erase_p;
    assign flash_row_addr_out  = {q.adr_hi, q.adr_lo[15:`FSPC_ROW_LSB],
                                  `FSPC_ROW_LSB'(0)};
    assign flash_prog_out      = q.prog_we;
    assign flash_prog_idx_out  = q.prog_idx;
    assign flash_prog_data_out = lat_rd;
endmodule
`default_nettype wire

// [bench/fspc_ctrl_props.sv]
// Assertion checker for the flash self-programming controller
`timescale 1ns/1ps
`default_nettype none
module fspc_ctrl_props #(
    parameter int OP_CYCLES = 64
) (
    input wire logic        clk_in,
    input wire logic        reset_n_in,
    input wire logic        tbl_valid_in,
    input wire logic        tbl_ready_out,
    input wire logic [15:0] tbl_ea_in,
    input wire logic        tbl_done_out,
    input wire logic        core_stall_out,
    input wire logic [23:0] flash_rd_addr_out,
    input wire logic        flash_erase_out,
    input wire logic [23:0] flash_row_addr_out,
    input wire logic        flash_prog_out,
    input wire logic [4:0]  flash_prog_idx_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    logic [31:0] stall_cnt;
    // ====================================
    // Busy cycle count
    always_ff @(posedge clk_in) begin
        if (!reset_n_in || !core_stall_out) begin
            stall_cnt <= 32'h0;
        end else begin
            stall_cnt <= stall_cnt + 32'h1;
        end
    end
    // ====================================
    // Properties
    sequence s_take;
        tbl_valid_in && tbl_ready_out;
    endsequence
    sequence s_answer;
        !tbl_done_out ##1 tbl_done_out;
    endsequence
    property p_tbl_done;
        s_take |=> s_answer;
    endproperty
    property p_tbl_hold;
        s_take |=> !tbl_ready_out [*2];
    endproperty
    property p_rd_addr;
        s_take |=> flash_rd_addr_out[15:0] == $past(tbl_ea_in);
    endproperty
    property p_stall_len;
        $fell(core_stall_out) |-> stall_cnt == 32'(OP_CYCLES);
    endproperty
    property p_stall_lock;
        core_stall_out |-> !tbl_ready_out;
    endproperty
    property p_start;
        $rose(core_stall_out) |=> flash_erase_out || flash_prog_out;
    endproperty
    property p_erase_once;
        flash_erase_out |=> !flash_erase_out && core_stall_out;
    endproperty
    property p_row;
        flash_erase_out |-> flash_row_addr_out[5:0] == 6'h00;
    endproperty
    property p_prog_seq;
        flash_prog_out && flash_prog_idx_out != 5'h1F |=> flash_prog_out
            && flash_prog_idx_out == $past(flash_prog_idx_out) + 5'h01;
    endproperty
    property p_prog_first;
        $rose(flash_prog_out) |-> flash_prog_idx_out == 5'h00;
    endproperty
    property p_idle_quiet;
        !core_stall_out |-> !flash_erase_out && !flash_prog_out;
    endproperty
    a_tbl_done: assert property (p_tbl_done)
        else $error("table done late");
    a_tbl_hold: assert property (p_tbl_hold)
        else $error("table ready early");
    a_rd_addr: assert property (p_rd_addr)
        else $error("bad read address");
    a_stall_len: assert property (p_stall_len)
        else $error("busy length wrong");
    a_stall_lock: assert property (p_stall_lock)
        else $error("table taken busy");
    a_start: assert property (p_start)
        else $error("no start action");
    a_erase_once: assert property (p_erase_once)
        else $error("erase not single");
    a_row: assert property (p_row)
        else $error("erase row not aligned");
    a_prog_seq: assert property (p_prog_seq)
        else $error("program burst broken");
    a_prog_first: assert property (p_prog_first)
        else $error("burst not from 0");
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("action while idle");
endmodule

bind fspc_ctrl fspc_ctrl_props #(.OP_CYCLES(OP_CYCLES)) u_props (
    .clk_in, .reset_n_in, .tbl_valid_in, .tbl_ready_out, .tbl_ea_in,
    .tbl_done_out, .core_stall_out, .flash_rd_addr_out, .flash_erase_out,
    .flash_row_addr_out, .flash_prog_out, .flash_prog_idx_out);
`default_nettype wire

// [bench/fspc_flash_model.sv]
// Program flash array model behind the controller
`timescale 1ns/1ps
`default_nettype none
module fspc_flash_model (
    input  wire logic        clk_in,
    input  wire logic [23:0] rd_addr_in,
    output logic      [23:0] rd_data_out,
    input  wire logic        erase_in,
    input  wire logic [23:0] row_addr_in,
    input  wire logic        prog_in,
    input  wire logic [4:0]  prog_idx_in,
    input  wire logic [23:0] prog_data_in
);
    logic [23:0] row [0:31];
    logic [23:0] last_row = 24'h0;
    int          erase_count = 0;
    int          prog_count = 0;
    assign rd_data_out = {rd_addr_in[23:16] ^ 8'h3C, rd_addr_in[15:0] ^ 16'h5A5A};
    always @(posedge clk_in) begin
        if (erase_in) begin
            erase_count <= erase_count + 1;
            last_row <= row_addr_in;
        end
        if (prog_in) begin
            row[prog_idx_in] <= prog_data_in;
            prog_count <= prog_count + 1;
            last_row <= row_addr_in;
        end
    end
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking testbench for the flash self-programming controller
`timescale 1ns/1ps
`default_nettype none
`include "fspc_regs.svh"
module tb_top;
    localparam logic [7:0] CT = `FSPC_CTRL_OFS;
    localparam logic [7:0] AL = `FSPC_ADRL_OFS;
    localparam logic [7:0] AH = `FSPC_ADRH_OFS;
    localparam logic [7:0] KY = `FSPC_KEY_OFS;
    localparam logic [1:0] OK = `FSPC_RESP_OKAY;
    localparam logic [1:0] ER = `FSPC_RESP_SLVERR;
    logic        clk_in = 1'h0, reset_n_in = 1'h0;
    logic        s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0;
    logic        s_axi_bready_in = 1'h0, s_axi_arvalid_in = 1'h0;
    logic        s_axi_rready_in = 1'h0, tbl_valid_in = 1'h0;
    logic        tbl_write_in = 1'h0, tbl_high_in = 1'h0, tbl_byte_in = 1'h0;
    logic [7:0]  s_axi_awaddr_in = 8'h0, s_axi_araddr_in = 8'h0;
    logic [31:0] s_axi_wdata_in = 32'h0;
    logic [3:0]  s_axi_wstrb_in = 4'h0;
    logic [15:0] tbl_ea_in = 16'h0, tbl_wdata_in = 16'h0;
    wire logic   s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
    wire logic   s_axi_arready_out, s_axi_rvalid_out, tbl_ready_out;
    wire logic   tbl_done_out, core_stall_out, flash_erase_out, flash_prog_out;
    wire logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
    wire logic [31:0] s_axi_rdata_out;
    wire logic [15:0] tbl_rdata_out;
    wire logic [23:0] flash_rd_addr_out, flash_rd_data_in, flash_row_addr_out;
    wire logic [23:0] flash_prog_data_out;
    wire logic [4:0]  flash_prog_idx_out;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;

    fspc_ctrl #(.OP_CYCLES(64)) dut (.*);
    fspc_flash_model u_flash (.clk_in(clk_in), .rd_addr_in(flash_rd_addr_out),
        .rd_data_out(flash_rd_data_in), .erase_in(flash_erase_out),
        .row_addr_in(flash_row_addr_out), .prog_in(flash_prog_out),
        .prog_idx_in(flash_prog_idx_out), .prog_data_in(flash_prog_data_out));

    initial begin
        forever #10 clk_in = ~clk_in;
    end
    // ====================================
    // Reporting
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end
    // ====================================
    // Bus and table port drivers
    task automatic wr(input logic [7:0] a, input logic [15:0] d,
                      input logic [1:0] e);
        logic ta, tw, tb;
        logic [1:0] r;
        @(posedge clk_in);
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= {16'h0, d};
        s_axi_wstrb_in <= 4'h3;
        do begin
            @(negedge clk_in);
            ta = s_axi_awready_out;
            tw = s_axi_wready_out;
            tb = s_axi_bvalid_out;
            r = s_axi_bresp_out;
            @(posedge clk_in);
            if (ta) s_axi_awvalid_in <= 1'h0;
            if (tw) s_axi_wvalid_in <= 1'h0;
        end while (!tb);
        s_axi_bready_in <= 1'h0;
        chk(32'(r), 32'(e));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input logic [1:0] e);
        logic ta, t;
        logic [1:0] r;
        logic [31:0] d;
        @(posedge clk_in);
        {s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
        s_axi_araddr_in <= a;
        do begin
            @(negedge clk_in);
            ta = s_axi_arready_out;
            t = s_axi_rvalid_out;
            d = s_axi_rdata_out;
            r = s_axi_rresp_out;
            @(posedge clk_in);
            if (ta) s_axi_arvalid_in <= 1'h0;
        end while (!t);
        s_axi_rready_in <= 1'h0;
        chk(32'(r), 32'(e));
        chk(d, x);
    endtask
    task automatic tbl(input logic [2:0] m, input logic [15:0] ea, wd, x);
        logic t;
        @(posedge clk_in);
        {tbl_valid_in, tbl_write_in, tbl_high_in, tbl_byte_in} <= {1'h1, m};
        tbl_ea_in <= ea;
        tbl_wdata_in <= wd;
        do begin
            @(negedge clk_in);
            t = tbl_ready_out;
            @(posedge clk_in);
        end while (!t);
        tbl_valid_in <= 1'h0;
        @(negedge clk_in);
        @(negedge clk_in);
        chk(32'(tbl_done_out), 32'h1);
        if (!m[2]) chk(32'(tbl_rdata_out), 32'(x));
    endtask
    task automatic op(input logic [15:0] c, input logic [7:0] k, input logic e);
        logic s;
        wr(CT, c, OK);
        if (k != 8'h00) begin
            wr(KY, 16'h0055, OK);
            if (k != 8'hAA) wr(KY, {8'h00, k}, OK);
            wr(KY, 16'h00AA, OK);
        end
        wr(CT, c | 16'h8000, OK);
        s = 1'h0;
        repeat (4) begin
            @(negedge clk_in);
            s = s | core_stall_out;
        end
        chk(32'(s), 32'(e));
        rd(CT, 32'(e ? c | 16'h8000 : c | 16'h2000), OK);
        while (core_stall_out) @(posedge clk_in);
        rd(CT, 32'(e ? c : c | 16'h2000), OK);
    endtask
    // ====================================
    // Scenarios
    task automatic t_reset();
        rd(CT, 32'h0, OK);
        rd(AL, 32'h0, OK);
        rd(AH, 32'h0, OK);
        rd(KY, 32'h0, OK);
        rd(8'h14, 32'h0, ER);
        wr(8'h14, 16'hFFFF, ER);
        $display("test reset done");
    endtask
    task automatic t_table();
        wr(`FSPC_PAGE_OFS, 16'h0012, OK);
        tbl(3'h0, 16'h1234, 16'h0, 16'h486E);
        chk(32'(flash_rd_addr_out), 32'h121234);
        rd(AL, 32'h1234, OK);
        rd(AH, 32'h0012, OK);
        tbl(3'h2, 16'h1234, 16'h0, 16'h002E);
        tbl(3'h1, 16'h1235, 16'h0, 16'h0048);
        $display("test table done");
    endtask
    task automatic t_erase();
        wr(AL, 16'h1F7F, OK);
        wr(AH, 16'h0003, OK);
        op(16'h4041, 8'hAA, 1'h1);
        chk(32'(u_flash.last_row), 32'h031F40);
        op(16'h4041, 8'h00, 1'h0);
        op(16'h4041, 8'h12, 1'h0);
        chk(32'(u_flash.erase_count), 32'h1);
        $display("test erase done");
    endtask
    task automatic t_program();
        wr(`FSPC_PAGE_OFS, 16'h0000, OK);
        for (int i = 0; i < 32; i++) begin
            tbl(3'h4, 16'h6000 + 16'(2 * i), 16'h1000 + 16'(i), 16'h0);
            tbl(3'h6, 16'h6000 + 16'(2 * i), 16'h0040 + 16'(i), 16'h0);
        end
        chk(32'(u_flash.prog_count), 32'h0);
        op(16'h4001, 8'hAA, 1'h1);
        for (int i = 0; i < 32; i++) begin
            chk(32'(u_flash.row[i]), 32'(24'h401000 + 24'(i) * 24'h010001));
        end
        chk(32'(u_flash.prog_count), 32'd32);
        chk(32'(u_flash.last_row), 32'h006000);
        $display("test program done");
    endtask

    initial begin
        repeat (16) @(posedge clk_in);
        reset_n_in <= 1'h1;
        t_reset();
        t_table();
        t_erase();
        t_program();
        conclude();
    end
endmodule
`default_nettype wire
